// ### dpt_map.svh
`ifndef DPT_MAP_SVH
`define DPT_MAP_SVH
// register byte offsets
`define DPT_CTRL_OFF 8'h00
`define DPT_RELOAD0_OFF 8'h04
`define DPT_RELOAD1_OFF 8'h08
`define DPT_COUNT0_OFF 8'h0C
`define DPT_COUNT1_OFF 8'h10
`define DPT_CLKDIV_OFF 8'h14
// control fields
`define DPT_RUN0_BIT 0
`define DPT_RUN1_BIT 1
`define DPT_PTOE_BIT 2
`define DPT_EVSEL_BIT 3
`define DPT_FASTON_BIT 4
`define DPT_SRCFAST_BIT 5
`define DPT_OUTSEL_BIT 6
`define DPT_CTRL_RST 7'h00
`define DPT_RELOAD_RST 8'hFF
// slow divider default, fast divider default (input clock enables)
`define DPT_SLOWDIV_RST 16'h0BEB
`define DPT_FASTDIV_RST 16'h0018
`endif

// ### dpt_pkg.sv
package dpt_pkg;
  typedef logic [7:0] dpt_count_t;
  typedef enum logic [1:0] {
    DPT_IDLE = 2'b00,
    DPT_RUN = 2'b01,
    DPT_STOPPING = 2'b11
  } dpt_state_e;
endpackage : dpt_pkg

// ### dpt_timer.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "dpt_map.svh"
module dpt_timer
  import dpt_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // external event pin for timer 0
  input wire logic event_pin,
  // outputs
  output logic timer_pulse_signal,
  output logic serial_clock,
  output logic fast_oscillator_on
);
  logic [6:0] ctrl_ff;
  logic [7:0] reload_ff [2];
  dpt_count_t count_ff [2];
  dpt_state_e state_ff [2];
  logic [15:0] slow_div_ff;
  logic [15:0] fast_div_ff;
  logic [15:0] div_cnt_ff;
  logic in_clk_ff;
  logic in_fall;
  logic ev_s1_ff;
  logic ev_s2_ff;
  logic ev_s3_ff;
  logic ev_fall;
  logic [1:0] uflow;
  logic [1:0] timer_pulse_signal_ff;
  logic [3:0] high_latch_ff [2];
  logic aw_ok_ff;
  logic w_ok_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic wr_do;
  logic [15:0] nxt_div;

  // write channel capture; address and data accepted in either order
  assign awready = !aw_ok_ff && !bvalid;
  assign wready = !w_ok_ff && !bvalid;
  assign wr_do = aw_ok_ff && w_ok_ff;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      bvalid <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_ok_ff <= 1'b1;
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_ok_ff <= 1'b1;
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
      if (wr_do)
      begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        bvalid <= 1'b1;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end
  assign bresp = (aw_addr_ff[7:2] > `DPT_CLKDIV_OFF >> 2) ? 2'b10 : 2'b00;

  // register writes; fast oscillator off after reset
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_ff <= `DPT_CTRL_RST;
      reload_ff[0] <= `DPT_RELOAD_RST;
      reload_ff[1] <= `DPT_RELOAD_RST;
      slow_div_ff <= `DPT_SLOWDIV_RST;
      fast_div_ff <= `DPT_FASTDIV_RST;
    end
    else if (wr_do && w_strb_ff[0])
    begin
      case (aw_addr_ff)
        `DPT_CTRL_OFF: ctrl_ff <= w_data_ff[6:0];
        `DPT_RELOAD0_OFF: reload_ff[0] <= w_data_ff[7:0];
        `DPT_RELOAD1_OFF: reload_ff[1] <= w_data_ff[7:0];
        `DPT_CLKDIV_OFF:
        begin
          slow_div_ff <= w_data_ff[15:0];
          if (w_strb_ff[2])
            fast_div_ff <= w_data_ff[31:16];
        end
        default: ;
      endcase
    end
  end
  // fast source without its oscillator on gives no input clock
  assign fast_oscillator_on = ctrl_ff[`DPT_FASTON_BIT];

  // input clock: divider toggles a square wave; decisions made at its fall
  assign nxt_div = ctrl_ff[`DPT_SRCFAST_BIT] ? fast_div_ff : slow_div_ff;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_cnt_ff <= 16'h0000;
      in_clk_ff <= 1'b0;
    end
    else if (!ctrl_ff[`DPT_SRCFAST_BIT] || ctrl_ff[`DPT_FASTON_BIT])
    begin
      if (div_cnt_ff >= nxt_div)
      begin
        div_cnt_ff <= 16'h0000;
        in_clk_ff <= !in_clk_ff;
      end
      else
        div_cnt_ff <= div_cnt_ff + 16'h0001;
    end
  end
  assign in_fall = in_clk_ff && (div_cnt_ff >= nxt_div) && (!ctrl_ff[`DPT_SRCFAST_BIT] || ctrl_ff[`DPT_FASTON_BIT]);

  // event pin synchroniser, falling edge as count event
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ev_s1_ff <= 1'b0;
      ev_s2_ff <= 1'b0;
      ev_s3_ff <= 1'b0;
    end
    else
    begin
      ev_s1_ff <= event_pin;
      ev_s2_ff <= ev_s1_ff;
      ev_s3_ff <= ev_s2_ff;
    end
  end
  assign ev_fall = ev_s3_ff && !ev_s2_ff;

  // two down counters, identical except that timer 0 can count pin events
  for (genvar i = 0; i < 2; i++)
  begin : g_tmr
    logic tick;
    logic run_req;
    assign run_req = ctrl_ff[i];
    // timer 0 counts pin events when selected; otherwise the input clock
    assign tick = (i == 0 && ctrl_ff[`DPT_EVSEL_BIT]) ? ev_fall : in_fall;
    assign uflow[i] = tick && state_ff[i] != DPT_IDLE && count_ff[i] == 8'h00;
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        state_ff[i] <= DPT_IDLE;
        count_ff[i] <= 8'h00;
        timer_pulse_signal_ff[i] <= 1'b0;
      end
      else if (tick)
      begin
        case (state_ff[i])
          DPT_IDLE:
          begin
            if (run_req)
              state_ff[i] <= DPT_RUN;
          end
          DPT_RUN:
          begin
            count_ff[i] <= (count_ff[i] == 8'h00) ? reload_ff[i] : count_ff[i] - 8'h01;
            if (count_ff[i] == 8'h00)
              timer_pulse_signal_ff[i] <= !timer_pulse_signal_ff[i];
            if (!run_req)
              state_ff[i] <= DPT_STOPPING;
          end
          DPT_STOPPING:
          begin
            // halt at this decrement
            count_ff[i] <= (count_ff[i] == 8'h00) ? reload_ff[i] : count_ff[i] - 8'h01;
            state_ff[i] <= run_req ? DPT_RUN : DPT_IDLE;
          end
          default: state_ff[i] <= DPT_IDLE;
        endcase
      end
    end
    // high nibble frozen when low nibble read; only timer 0's held nibble can be read back, at offset +1
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
        high_latch_ff[i] <= 4'h0;
      else if (arvalid && arready && araddr == (i == 0 ? `DPT_COUNT0_OFF : `DPT_COUNT1_OFF))
        high_latch_ff[i] <= count_ff[i][7:4];
    end
  end

  // pulse output: plain and gate, so an enable change may glitch
  assign timer_pulse_signal = timer_pulse_signal_ff[ctrl_ff[`DPT_OUTSEL_BIT]] & ctrl_ff[`DPT_PTOE_BIT];
  assign serial_clock = timer_pulse_signal_ff[1];

  // read channel
  assign arready = !rvalid;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'b00;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rresp <= 2'b00;
      case (araddr)
        // run bits read 1 until the counter has stopped
        `DPT_CTRL_OFF: rdata <= {25'h0, ctrl_ff[6:2],
                                 ctrl_ff[1] | (state_ff[1] != DPT_IDLE),
                                 ctrl_ff[0] | (state_ff[0] != DPT_IDLE)};
        `DPT_RELOAD0_OFF: rdata <= {24'h0, reload_ff[0]};
        `DPT_RELOAD1_OFF: rdata <= {24'h0, reload_ff[1]};
        // low nibble in [3:0], live high nibble in [7:4]
        `DPT_COUNT0_OFF: rdata <= {24'h0, count_ff[0][7:4], count_ff[0][3:0]};
        `DPT_COUNT1_OFF: rdata <= {24'h0, count_ff[1][7:4], count_ff[1][3:0]};
        `DPT_COUNT0_OFF + 8'h01: rdata <= {28'h0, high_latch_ff[0]};
        `DPT_CLKDIV_OFF: rdata <= {fast_div_ff, slow_div_ff};
        default:
        begin
          rdata <= 32'h0;
          rresp <= 2'b10;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // stopping with run bit 0 returns to idle on the mclk cycle after a tick
  stop_after_tick_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (g_tmr[0].tick && state_ff[0] == DPT_STOPPING && !ctrl_ff[0]) |=> state_ff[0] == DPT_IDLE)
    else $error("timer0 did not halt at decrement");
  run_sync_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!g_tmr[0].tick && state_ff[0] == DPT_IDLE) |=> state_ff[0] == DPT_IDLE)
    else $error("timer0 started off input edge");
  run_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (rvalid && $past(arvalid && arready && araddr == `DPT_CTRL_OFF) && $past(state_ff[0] != DPT_IDLE))
      |-> rdata[0])
    else $error("run bit read 0 while running");
  fast_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) |-> !fast_oscillator_on)
    else $error("fast oscillator on after reset");
  no_fast_clk_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (ctrl_ff[`DPT_SRCFAST_BIT] && !ctrl_ff[`DPT_FASTON_BIT]) |-> !in_fall)
    else $error("input clock ran without fast oscillator");
  pulse_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !ctrl_ff[`DPT_PTOE_BIT] |-> !timer_pulse_signal)
    else $error("pulse output not gated");
  count_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (g_tmr[1].tick && state_ff[1] == DPT_RUN && count_ff[1] != 8'h00) |=> count_ff[1] == $past(count_ff[1]) - 8'h01)
    else $error("timer1 decrement wrong");
  hold_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    state_ff[1] == DPT_IDLE |=> count_ff[1] == $past(count_ff[1]))
    else $error("timer1 counted while stopped");
  read_answer_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (arvalid && arready) |=> rvalid)
    else $error("read answer late");
  uflow_c: cover property (@(posedge mclk) disable iff (!reset_n) uflow[0]);
  evt_c: cover property (@(posedge mclk) disable iff (!reset_n) ctrl_ff[`DPT_EVSEL_BIT] && ev_fall && state_ff[0] != DPT_IDLE);
  stop_c: cover property (@(posedge mclk) disable iff (!reset_n) state_ff[1] == DPT_STOPPING);
  pulse_c: cover property (@(posedge mclk) disable iff (!reset_n) $rose(timer_pulse_signal));
endmodule : dpt_timer

// ### test_dual_programmable_down_timer.sv
`timescale 1ns/100ps
`include "dpt_map.svh"
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module test_dual_programmable_down_timer
  import dpt_pkg::*;
;
  logic mclk, reset_n, awvalid, wvalid, bready, arvalid, rready, event_pin;
  logic awready, wready, bvalid, arready, rvalid, timer_pulse_signal, serial_clock, fast_oscillator_on;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  dpt_count_t c1, c2;
  integer seed;
  int error_cnt, samples_checked, cyc, t, p, s, rel, polls;

  dpt_timer dpt_timer_i (.mclk(mclk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .event_pin(event_pin), .timer_pulse_signal(timer_pulse_signal),
    .serial_clock(serial_clock), .fast_oscillator_on(fast_oscillator_on));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // edges of the toggle output over n cycles, reload r, slow half period div+1
  function int exp_edges(input int n, input int div, input int r);
    return n / (2 * (div + 1) * (r + 1));
  endfunction : exp_edges

  // glitches on enable may add an edge or two
  function logic near(input int a, input int b);
    return (a >= b - 2) && (a <= b + 2);
  endfunction : near

  // count after k decrements from c, reloading r at zero
  function int exp_cnt(input int c, input int r, input int k);
    int v;
    v = c;
    repeat (k) v = (v == 0) ? r : v - 1;
    return v;
  endfunction : exp_cnt

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] resp;
    begin
      b_hs = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_hs)
      begin
        @(negedge mclk);
        aw_hs = awvalid && awready;
        w_hs = wvalid && wready;
        b_hs = bvalid === 1'b1;
        resp = bresp;
        @(posedge mclk);
        if (aw_hs) awvalid <= 1'b0;
        if (w_hs) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      `CHK(resp, 2'b00)
      @(posedge mclk);
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar_hs, r_hs;
    begin
      r_hs = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_hs)
      begin
        @(negedge mclk);
        ar_hs = arvalid && arready;
        r_hs = rvalid === 1'b1;
        v = rdata;
        rs = rresp;
        @(posedge mclk);
        if (ar_hs) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge mclk);
    end
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    begin
      axi_rd(a, d, r);
      `CHK(d, ev)
      `CHK(r, er)
    end
  endtask : rd_chk

  task automatic count_edges(input int n, output int pe, output int se);
    logic lp, ls;
    begin
      pe = 0;
      se = 0;
      @(negedge mclk);
      lp = timer_pulse_signal;
      ls = serial_clock;
      repeat (n)
      begin
        @(negedge mclk);
        if (timer_pulse_signal !== lp) pe++;
        if (serial_clock !== ls) se++;
        lp = timer_pulse_signal;
        ls = serial_clock;
      end
      @(posedge mclk);
    end
  endtask : count_edges

  task conclude;
    begin
      if (error_cnt == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask : conclude

  // ceiling well above the roughly 8k cycles the sequence needs
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      conclude();
    end
  end

  initial
  begin
    seed = 32'h9C2B;
    {reset_n, awvalid, wvalid, bready, arvalid, rready, event_pin} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    `CHK(fast_oscillator_on, 1'b0)
    rd_chk(`DPT_CTRL_OFF, {25'h0, `DPT_CTRL_RST}, 2'b00);
    rd_chk(`DPT_RELOAD1_OFF, {24'h0, `DPT_RELOAD_RST}, 2'b00);
    rd_chk(`DPT_CLKDIV_OFF, {`DPT_FASTDIV_RST, `DPT_SLOWDIV_RST}, 2'b00);
    rd_chk(8'h18, 32'h0, 2'b10);
    // fast source while its oscillator is off: no input clock at all
    axi_wr(`DPT_CLKDIV_OFF, 32'h0018_0001);
    axi_wr(`DPT_RELOAD0_OFF, 32'h2);
    axi_wr(`DPT_CTRL_OFF, 32'h25);
    count_edges(400, p, s);
    `CHK(p, 0)
    for (t = 0; t < 2; t++)
    begin
      rel = 4 + ($random(seed) & 7);
      axi_wr(t ? `DPT_RELOAD1_OFF : `DPT_RELOAD0_OFF, rel);
      axi_wr(`DPT_CTRL_OFF, t ? 32'h42 : 32'h01);
      count_edges(1200, p, s);
      `CHK(p, 0)
      axi_wr(`DPT_CTRL_OFF, t ? 32'h46 : 32'h05);
      count_edges(2000, p, s);
      `CHK(near(p, exp_edges(2000, 1, rel)), 1'b1)
      if (t) `CHK(near(s, exp_edges(2000, 1, rel)), 1'b1)
    end
    // slow input clock so the stop lag is visible
    axi_wr(`DPT_CLKDIV_OFF, 32'h0018_003F);
    axi_wr(`DPT_CTRL_OFF, 32'h01);
    axi_rd(`DPT_COUNT0_OFF, d, r);
    c1 = d[7:0];
    repeat (300) @(posedge mclk);
    axi_rd(`DPT_COUNT0_OFF, d, r);
    c2 = d[7:0];
    `CHK(c1 !== c2, 1'b1)
    axi_wr(`DPT_CTRL_OFF, 32'h00);
    // stop needs two input clock falls, far more than one read
    axi_rd(`DPT_CTRL_OFF, d, r);
    `CHK(d[`DPT_RUN0_BIT], 1'b1)
    for (polls = 0; polls < 120 && d[0] === 1'b1; polls++)
      axi_rd(`DPT_CTRL_OFF, d, r);
    `CHK(d[`DPT_RUN0_BIT], 1'b0)
    axi_rd(`DPT_COUNT0_OFF, d, r);
    c1 = d[7:0];
    `CHK(d[31:8], 24'h0)
    repeat (400) @(posedge mclk);
    axi_rd(`DPT_COUNT0_OFF, d, r);
    `CHK(d[7:0], c1)
    // event count mode on timer 0: the first pin fall only starts it
    rel = 4 + ($random(seed) & 7);
    axi_wr(`DPT_RELOAD0_OFF, rel);
    axi_wr(`DPT_CTRL_OFF, 32'h09);
    s = 2 + ($random(seed) & 7);
    repeat (s + 1)
    begin
      event_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      event_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
    axi_rd(`DPT_COUNT0_OFF, d, r);
    `CHK(d[7:0], exp_cnt(c1, rel, s))
    axi_wr(`DPT_CTRL_OFF, 32'h00);
    axi_wr(`DPT_CTRL_OFF, 32'h10);
    repeat (2) @(posedge mclk);
    `CHK(fast_oscillator_on, 1'b1)
    conclude();
  end
endmodule : test_dual_programmable_down_timer
